/* bench/line_src.sv */
/*
  Far-end line model: bipolar marks on two rails plus an amplitude word.
  Assumes the bench sets gap (0 is a silent line) and lvl on the clock.
*/
`timescale 1ns/1ps
module line_src (
  // clock
  input wire logic clk,
  // control from the bench
  input wire logic [7:0] gap,
  input wire logic [7:0] lvl,
  // line side
  output logic pos,
  output logic neg,
  output logic [7:0] amp
);
  int cnt = 0;
  logic pol = 1'b0;
  // quiet and strong line at time zero, so no alarm before the first edge
  logic pos_q = 1'b0;
  logic neg_q = 1'b0;
  logic [7:0] amp_q = 8'hff;
  ////////////////////////////////////////
  // one mark every gap bits, rails alternate as on a real bipolar line
  always @(posedge clk) begin
    cnt <= (cnt + 1 >= gap) ? 0 : cnt + 1;
    pos_q <= (gap != 0) && (cnt == 0) && !pol;
    neg_q <= (gap != 0) && (cnt == 0) && pol;
    if ((gap != 0) && (cnt == 0)) begin
      pol <= !pol;
    end
    amp_q <= lvl;
  end
  // one driver per output
  assign pos = pos_q;
  assign neg = neg_q;
  assign amp = amp_q;
endmodule // line_src

/* bench/test_loss_of_signal_detect.sv */
/*
  Self-checking bench of the loss-of-signal detector against a reference model.
  Assumes los_cfg.svh on the include path and line_src as the far end.
*/
`timescale 1ns/1ps
`include "los_cfg.svh"
module test_loss_of_signal_detect;
  localparam int ZR = 8;
  localparam int W = 4;
  logic clock = 1'b0;
  logic nrst = 1'b0;
  logic hsel = 1'b0;
  logic hwrite = 1'b0;
  logic [1:0] htrans = 2'b00;
  logic [31:0] haddr = 32'h0;
  logic [31:0] hwdata = 32'h0;
  logic [31:0] hrdata;
  logic hreadyout, hresp, rpos, rneg, los, irq;
  logic [7:0] amp;
  logic [7:0] gap = 8'h02;
  logic [7:0] lvl = 8'hff;
  logic [31:0] seed = 32'h00000055;
  logic [15:0] m_thr = 16'h6040;
  logic m_dig = 1'b0;
  logic m_ana = 1'b0;
  logic [31:0] rv;
  logic q[$];
  logic [7:0] adr[5] = '{8'h00, 8'h04, 8'h08, 8'h0c, 8'h10};
  logic [31:0] rst[5] = '{32'h0, 32'h0, 32'h0, 32'h6040, 32'h0};
  int run = 0;
  int err_total = 0;
  int tests_run = 0;
  int dens = 0;
  logic resp_bad = 1'b0;

  always #20 clock = ~clock;

  loss_of_signal_detect #(.ZERO_RUN(ZR), .DENS_WIN(W), .DENS_PCT(33)) u_loss_of_signal_detect (
    .CLOCK(clock), .NRST(nrst), .HSEL(hsel), .HADDR(haddr), .HTRANS(htrans), .HWRITE(hwrite),
    .HSIZE(3'b010), .HWDATA(hwdata), .HREADY(hreadyout), .HRDATA(hrdata), .HREADYOUT(hreadyout),
    .HRESP(hresp), .RPOS(rpos), .RNEG(rneg), .AMP(amp), .LOS(los), .IRQ(irq));
  line_src u_line_src (.clk(clock), .gap(gap), .lvl(lvl), .pos(rpos), .neg(rneg), .amp(amp));
  ////////////////////////////////////////
  // reference detectors; a sliding window equals fixed ones on even patterns
  always @(posedge clock) begin
    run = (rpos | rneg) ? 0 : run + 1;
    q.push_back(rpos | rneg);
    if (q.size() > W) void'(q.pop_front());
    dens = 0;
    foreach (q[k]) dens += int'(q[k]);
    if (!nrst) begin
      m_dig = 1'b0;
      m_ana = 1'b0;
    end else begin
      if (run >= ZR) m_dig = 1'b1;
      else if (dens * 100 >= 33 * W) m_dig = 1'b0;
      if (amp < m_thr[7:0]) m_ana = 1'b1;
      else if (amp > m_thr[15:8]) m_ana = 1'b0;
    end
  end
  ////////////////////////////////////////
  function automatic logic [31:0] xs(input logic [31:0] s);
    logic [31:0] t;
    t = s ^ (s << 13);
    t = t ^ (t >> 17);
    return t ^ (t << 5);
  endfunction
  // one single AHB-Lite word transfer, held until hready is seen
  task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] d, output logic [31:0] r);
    hsel <= 1'b1;
    haddr <= {24'h0, a};
    htrans <= 2'b10;
    hwrite <= w;
    do @(posedge clock); while (hreadyout !== 1'b1);
    hsel <= 1'b0;
    htrans <= 2'b00;
    hwdata <= d;
    do @(posedge clock); while (hreadyout !== 1'b1);
    r = hrdata;
    resp_bad = resp_bad | (hresp !== 1'b0);
  endtask
  task automatic chk(input string nm, input logic [31:0] got, input logic [31:0] exp);
    tests_run++;
    if (got !== exp) begin
      err_total++;
      $display("BAD %0t %s got %h exp %h", $time, nm, got, exp);
    end
  endtask
  // set a line condition, let it settle, then compare word and pin
  task automatic step(input string nm, input logic [7:0] g, input logic [7:0] l);
    gap <= g;
    lvl <= l;
    repeat (4 * ZR + 4 * W) @(posedge clock);
    xfer(1'b0, `LOS_OFF_ALARM, 32'h0, rv);
    chk(nm, rv, {26'h0, m_dig, m_ana, 2'b00, m_dig | m_ana, 1'b0});
    chk(nm, {31'h0, los}, {31'h0, m_dig | m_ana});
    $display("test %s done", nm);
  endtask
  task automatic give_verdict();
    $display("compares %0d mismatches %0d", tests_run, err_total);
    if (err_total == 0 && tests_run > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask
  ////////////////////////////////////////
  initial begin
    repeat (10) @(posedge clock);
    nrst <= 1'b1;
    @(posedge clock);
    foreach (adr[i]) begin
      xfer(1'b0, adr[i], 32'h0, rv);
      chk("reset value", rv, rst[i]);
    end
    $display("test reset values done");
    // status is read only, the next read must not show this write
    xfer(1'b1, `LOS_OFF_ALARM, 32'hff, rv);
    step("dense", 8'h02, 8'hff);
    step("near miss", 8'(ZR), 8'hff);
    xfer(1'b1, `LOS_OFF_MASK, 32'h0, rv);
    xfer(1'b0, `LOS_OFF_INT, 32'h0, rv);
    step("silent run", 8'(ZR + 1), 8'hff);
    chk("irq masked", {31'h0, irq}, 32'h0);
    xfer(1'b1, `LOS_OFF_MASK, 32'h2, rv);
    repeat (2) @(posedge clock);
    chk("irq raised", {31'h0, irq}, 32'h1);
    xfer(1'b0, `LOS_OFF_INT, 32'h0, rv);
    chk("int status", rv, 32'h22);
    repeat (2) @(posedge clock);
    chk("irq cleared", {31'h0, irq}, 32'h0);
    $display("test irq done");
    step("sparse hold", 8'h04, 8'hff);
    step("density clear", 8'h02, 8'hff);
    step("silence", 8'h00, 8'hff);
    step("full density", 8'h01, 8'hff);
    xfer(1'b1, `LOS_OFF_THR, 32'h5030, rv);
    xfer(1'b0, `LOS_OFF_THR, 32'h0, rv);
    chk("thr", rv, 32'h5030);
    m_thr <= 16'h5030;
    step("amp low", 8'h02, 8'h20);
    // random levels inside the hysteresis band must never move the alarm
    for (int i = 0; i < 8; i++) begin
      if (i == 4) step("amp high", 8'h02, 8'h51);
      seed = xs(seed);
      step("band hold", 8'(1 + seed[8]), 8'h31 + 8'(seed % 32));
    end
    step("both lost", 8'h00, 8'h20);
    chk("okay response", {31'h0, resp_bad}, 32'h0);
    $display("test bus response done");
    give_verdict();
  end
  // hang guard, far beyond the roughly one thousand cycles of the run
  initial begin
    #(40 * 8000);
    err_total++;
    give_verdict();
  end
endmodule // test_loss_of_signal_detect

/* logic/los_cfg.svh */
/*
  Constants of the loss-of-signal detector: register offsets, bit positions,
  reset values and detection counts.
  Assumes inclusion by bare name from the design files.
*/
`ifndef LOS_CFG_SVH
`define LOS_CFG_SVH

// byte offsets on the register bus
`define LOS_OFF_ALARM 8'h00
`define LOS_OFF_INT 8'h04
`define LOS_OFF_MASK 8'h08
`define LOS_OFF_THR 8'h0c

// bit positions inside the 8-bit alarm layout
`define LOS_BIT_DIG 5
`define LOS_BIT_ANA 4
`define LOS_BIT_LOS 1

// reset values
`define LOS_ALARM_RST 8'h00
`define LOS_MASK_RST 8'h00
`define LOS_THR_DECL_RST 8'h40
`define LOS_THR_CLR_RST 8'h60

// detection counts, in bit periods and percent
`define LOS_ZERO_RUN 160
`define LOS_DENS_WIN 32
`define LOS_DENS_PCT 33
`define LOS_PCT_FULL 100

`endif

/* logic/los_pkg.sv */
/*
  Types of the loss-of-signal detector.
  Assumes nothing beyond a SystemVerilog compiler.
*/
package los_pkg;

  // alarm status layout, also used for interrupt status and mask
  typedef struct packed {
    logic unused7;
    logic prbs6;
    logic dig_los;
    logic ana_los;
    logic fifo3;
    logic lock2;
    logic los;
    logic drive0;
  } alarm_t;

  // analog amplitude thresholds as held in the threshold register
  typedef struct packed {
    logic [7:0] clr;
    logic [7:0] decl;
  } thr_t;

endpackage

/* logic/loss_of_signal_detect.sv */
/*
  Loss-of-signal detector of one receive channel, with an AHB-Lite register
  slave, sticky change interrupts and one level interrupt output.
  Assumes CLOCK ticks once per line bit period, rail pulse pins are
  asynchronous, and the amplitude word comes from a converter on CLOCK.
*/
`timescale 1ns/1ps
`include "los_cfg.svh"

// Contract
// - declare digital loss after 160 empty bits
// - clear digital loss at density 33 percent
// - status bit 5 shows digital loss
// - channel loss is digital OR analog
// - status bit 4 shows analog loss
// - analog loss with declare/clear hysteresis
// - status bit 1 shows channel loss
module loss_of_signal_detect #(
  parameter int ZERO_RUN = `LOS_ZERO_RUN,
  parameter int DENS_WIN = `LOS_DENS_WIN,
  parameter int DENS_PCT = `LOS_DENS_PCT
) (
  // clock and reset
  input wire logic CLOCK,
  input wire logic NRST,
  // register bus
  input wire logic HSEL,
  input wire logic [31:0] HADDR,
  input wire logic [1:0] HTRANS,
  input wire logic HWRITE,
  input wire logic [2:0] HSIZE,
  input wire logic [31:0] HWDATA,
  input wire logic HREADY,
  output logic [31:0] HRDATA,
  output logic HREADYOUT,
  output logic HRESP,
  // line side
  input wire logic RPOS,
  input wire logic RNEG,
  input wire logic [7:0] AMP,
  // alarms
  output logic LOS,
  output logic IRQ
);

  localparam int ZW = $clog2(ZERO_RUN + 1);
  localparam int WW = $clog2(DENS_WIN + 1);
  // least pulse count per window meeting the density, rounded up
  localparam int DENS_MIN = (DENS_PCT * DENS_WIN + `LOS_PCT_FULL - 1) / `LOS_PCT_FULL;

  // elaboration checks
  if (ZERO_RUN < 2) begin : g_bad_run
    $error("ZERO_RUN must be at least 2");
  end
  if (DENS_WIN < 2 || DENS_PCT < 1 || DENS_PCT > `LOS_PCT_FULL) begin : g_bad_dens
    $error("density window or percentage out of range");
  end

  ////////////////////////////////////////////////////////////////////////////
  // line input synchronisers

  logic rpos_m_q, rpos_s_q, rneg_m_q, rneg_s_q;
  logic pulse;

  // pins are asynchronous to CLOCK
  always_ff @(posedge CLOCK or negedge NRST) begin
    if (!NRST) begin
      rpos_m_q <= 1'b0;
      rpos_s_q <= 1'b0;
      rneg_m_q <= 1'b0;
      rneg_s_q <= 1'b0;
    end else begin
      rpos_m_q <= RPOS;
      rpos_s_q <= rpos_m_q;
      rneg_m_q <= RNEG;
      rneg_s_q <= rneg_m_q;
    end
  end

  assign pulse = rpos_s_q | rneg_s_q; // a mark on either rail

  ////////////////////////////////////////////////////////////////////////////
  // digital detector

  logic [ZW-1:0] zero_cnt_q;
  logic [WW-1:0] win_cnt_q, pulse_cnt_q;
  logic [WW-1:0] pulse_cnt_d;
  logic win_end, run_hit, dens_ok;
  logic dig_los_q;

  assign run_hit = !pulse && (zero_cnt_q == ZW'(ZERO_RUN - 1));
  assign win_end = (win_cnt_q == WW'(DENS_WIN - 1));
  assign pulse_cnt_d = pulse_cnt_q + WW'(pulse);
  assign dens_ok = (pulse_cnt_d >= WW'(DENS_MIN));

  // empty bit counter, saturates so a long silence cannot wrap
  always_ff @(posedge CLOCK or negedge NRST) begin
    if (!NRST) begin
      zero_cnt_q <= '0;
    end else if (pulse) begin
      zero_cnt_q <= '0;
    end else if (zero_cnt_q != ZW'(ZERO_RUN)) begin
      zero_cnt_q <= zero_cnt_q + ZW'(1);
    end
  end

  // fixed density window, free running
  always_ff @(posedge CLOCK or negedge NRST) begin
    if (!NRST) begin
      win_cnt_q <= '0;
      pulse_cnt_q <= '0;
    end else if (win_end) begin
      win_cnt_q <= '0;
      pulse_cnt_q <= '0;
    end else begin
      win_cnt_q <= win_cnt_q + WW'(1);
      pulse_cnt_q <= pulse_cnt_d;
    end
  end

  // declare wins over clear; clear is judged only at a window end
  always_ff @(posedge CLOCK or negedge NRST) begin
    if (!NRST) begin
      dig_los_q <= 1'b0;
    end else if (run_hit) begin
      dig_los_q <= 1'b1;
    end else if (win_end && dens_ok) begin
      dig_los_q <= 1'b0;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // analog detector

  los_pkg::thr_t thr_q;
  logic ana_los_q;

  // between the two thresholds the state holds, so no chatter
  always_ff @(posedge CLOCK or negedge NRST) begin
    if (!NRST) begin
      ana_los_q <= 1'b0;
    end else if (AMP < thr_q.decl) begin
      ana_los_q <= 1'b1;
    end else if (AMP > thr_q.clr) begin
      ana_los_q <= 1'b0;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // channel state and alarm status

  los_pkg::alarm_t alarm_q, alarm_d;

  always_comb begin
    alarm_d = `LOS_ALARM_RST;
    alarm_d.dig_los = dig_los_q;
    alarm_d.ana_los = ana_los_q;
    alarm_d.los = dig_los_q | ana_los_q;
  end

  // alarm status and channel output share one flop stage
  always_ff @(posedge CLOCK or negedge NRST) begin
    if (!NRST) begin
      alarm_q <= `LOS_ALARM_RST;
      LOS <= 1'b0;
    end else begin
      alarm_q <= alarm_d;
      LOS <= alarm_d.los;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // bus slave

  logic acc, rd_acc, wr_q;
  logic [7:0] wr_off_q;
  logic [31:0] rd_val;
  los_pkg::alarm_t int_q, int_d, mask_q;
  logic int_rd;

  assign acc = HSEL && HREADY && HTRANS[1];
  assign rd_acc = acc && !HWRITE;
  assign int_rd = rd_acc && (HADDR[7:0] == `LOS_OFF_INT);

  // read mux; unmapped offsets read zero
  always_comb begin
    rd_val = '0;
    unique case (HADDR[7:0])
      `LOS_OFF_ALARM: rd_val[7:0] = alarm_q;
      `LOS_OFF_INT: rd_val[7:0] = int_q;
      `LOS_OFF_MASK: rd_val[7:0] = mask_q;
      `LOS_OFF_THR: rd_val[15:0] = thr_q;
      default: rd_val = '0;
    endcase
  end

  // zero wait states: read data latched at the address phase
  always_ff @(posedge CLOCK or negedge NRST) begin
    if (!NRST) begin
      HRDATA <= '0;
      HREADYOUT <= 1'b1;
      HRESP <= 1'b0;
    end else begin
      HRDATA <= rd_acc ? rd_val : '0;
      HREADYOUT <= 1'b1;
      HRESP <= 1'b0;
    end
  end

  // write address held for the data phase
  always_ff @(posedge CLOCK or negedge NRST) begin
    if (!NRST) begin
      wr_q <= 1'b0;
      wr_off_q <= '0;
    end else begin
      wr_q <= acc && HWRITE;
      wr_off_q <= HADDR[7:0];
    end
  end

  // writable registers; status registers ignore writes
  always_ff @(posedge CLOCK or negedge NRST) begin
    if (!NRST) begin
      mask_q <= `LOS_MASK_RST;
      thr_q.decl <= `LOS_THR_DECL_RST;
      thr_q.clr <= `LOS_THR_CLR_RST;
    end else if (wr_q && wr_off_q == `LOS_OFF_MASK) begin
      mask_q <= HWDATA[7:0];
    end else if (wr_q && wr_off_q == `LOS_OFF_THR) begin
      thr_q <= HWDATA[15:0];
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // change interrupts

  // a change arriving with the clearing read survives it
  always_comb begin
    int_d = int_rd ? `LOS_ALARM_RST : int_q;
    int_d.dig_los = int_d.dig_los | (alarm_d.dig_los ^ alarm_q.dig_los);
    int_d.ana_los = int_d.ana_los | (alarm_d.ana_los ^ alarm_q.ana_los);
    int_d.los = int_d.los | (alarm_d.los ^ alarm_q.los);
  end

  always_ff @(posedge CLOCK or negedge NRST) begin
    if (!NRST) begin
      int_q <= `LOS_ALARM_RST;
      IRQ <= 1'b0;
    end else begin
      int_q <= int_d;
      IRQ <= |(int_d & mask_q);
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // assertions

  default clocking cb @(posedge CLOCK); endclocking
  default disable iff (!NRST);

  sequence status_rd;
    rd_acc && HADDR[7:0] == `LOS_OFF_ALARM;
  endsequence

  sequence silence_end;
    !pulse && zero_cnt_q == ZW'(ZERO_RUN - 1);
  endsequence

  zero_run_a: assert property (silence_end |=> dig_los_q ##1 alarm_q.dig_los)
    else $error("digital loss not declared after empty run");

  density_clear_a: assert property (dig_los_q && win_end && dens_ok && !run_hit |=> !dig_los_q)
    else $error("digital loss not cleared on density");

  no_early_clear_a: assert property (dig_los_q && !(win_end && dens_ok) |=> dig_los_q)
    else $error("digital loss cleared without density");

  dig_status_a: assert property (status_rd |=> HRDATA[`LOS_BIT_DIG] == $past(dig_los_q, 2))
    else $error("status bit 5 wrong");

  or_state_a: assert property (##2 LOS == ($past(dig_los_q) || $past(ana_los_q)))
    else $error("channel loss is not the OR");

  ana_status_a: assert property (status_rd |=> HRDATA[`LOS_BIT_ANA] == $past(ana_los_q, 2))
    else $error("status bit 4 wrong");

  hyst_hold_a: assert property (AMP >= thr_q.decl && AMP <= thr_q.clr |=> $stable(ana_los_q))
    else $error("analog loss moved inside hysteresis");

  hyst_set_a: assert property (AMP < thr_q.decl |=> ana_los_q)
    else $error("analog loss not declared");

  hyst_clear_a: assert property (AMP > thr_q.clr && AMP >= thr_q.decl |=> !ana_los_q)
    else $error("analog loss not cleared");

  los_status_a: assert property (status_rd |=> HRDATA[`LOS_BIT_LOS] == $past(LOS))
    else $error("status bit 1 wrong");

  run_restart_a: assert property (pulse |=> zero_cnt_q == '0 ##1 !dig_los_q || $past(dig_los_q))
    else $error("empty count not restarted");

endmodule // loss_of_signal_detect
